//--- design/bridge_config_header_regs.sv
/*
 Configuration header dwords 08h to 1Ch of a reversible bridge, reached as a
 classic Wishbone slave. Bus number, timer, line size and I/O window values
 are driven out to the rest of the bridge.
 Assumes the direction and bus mode straps are quasi-static pins and that
 reset is held for at least three clock edges so the straps settle first.
*/
// The Wishbone register port was left to the implementer.
`default_nettype none

module bridge_config_header_regs
   import bridge_cfg_pkg::*;
#(
   parameter logic [7:0] REVISION = 8'h5a  // Value is arbitrary
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Straps from pins
   input wire logic forward_mode_i,
   input wire logic pcix_mode_i,
   // Programmed values to the bridge
   output logic [LINE_W-1:0] line_size_o,
   output logic [7:0] upstream_timer_o,
   output logic [7:0] downstream_timer_o,
   output logic [7:0] upstream_bus_o,
   output logic [7:0] downstream_bus_o,
   output logic [7:0] highest_bus_o,
   output logic [IO_NIB_W-1:0] io_base_o,
   output logic [IO_NIB_W-1:0] io_limit_o
);

   // Strap synchronisers; they run through reset so reset values see settled straps
   logic [STRAP_W-1:0] strap_meta;
   logic [STRAP_W-1:0] strap_sync;
   wire logic [STRAP_W-1:0] strap_raw = {pcix_mode_i, forward_mode_i};

   always_ff @(posedge clk_i) begin
      strap_meta <= strap_raw;
      strap_sync <= strap_meta;
   end

   wire logic forward = strap_sync[STRAP_FWD];
   wire logic pcix = strap_sync[STRAP_PCIX];
   wire logic [7:0] timer_rst = pcix ? TIMER_RST_PCIX : TIMER_RST_PCI;

   // Storage
   logic [LINE_W-1:0] line_size;
   logic [7:0] upstream_latency_timer;
   logic [7:0] downstream_latency_timer;
   logic [7:0] upstream_bus_number;
   logic [7:0] downstream_bus_number;
   logic [7:0] highest_bus_number;
   logic [IO_NIB_W-1:0] io_window_base;
   logic [IO_NIB_W-1:0] io_window_limit;

   // Bus decode
   wire logic req = cyc_i & stb_i;
   wire logic [ADR_W-1:0] dw_adr = {adr_i[ADR_W-1:2], 2'b00};
   wire logic hit_class = (dw_adr == OFS_CLASS);
   wire logic hit_header = (dw_adr == OFS_HEADER);
   wire logic hit_rsv = (dw_adr == OFS_RSV0) | (dw_adr == OFS_RSV1);
   wire logic hit_bus = (dw_adr == OFS_BUS);
   wire logic hit_io = (dw_adr == OFS_IO);

   // A write lands on the edge where the master sees ack
   wire logic wr = req & we_i & ack_o;
   wire logic [3:0] lane_wr = {4{wr}} & sel_i;

   // Read image of each dword
   wire logic [31:0] rd_class = {BASE_CLASS, SUB_CLASS, PROG_IF, REVISION};
   wire logic [31:0] rd_header = {HDR_TOP, HDR_MULTI_FN, HDR_LAYOUT,
                                  upstream_latency_timer,
                                  2'b00, line_size, 2'b00};
   wire logic [31:0] rd_bus = {downstream_latency_timer, highest_bus_number,
                               downstream_bus_number, upstream_bus_number};
   // Upper half of 1Ch belongs to the secondary status logic outside this bank
   wire logic [31:0] rd_io = {16'h0000,
                              io_window_limit, 2'b00, IO_ADDR_CAP,
                              io_window_base, 2'b00, IO_ADDR_CAP};

   // Reserved and unmapped dwords answer with zero rather than an error
   wire logic [31:0] rdata =
      hit_class ? rd_class :
      hit_header ? rd_header :
      hit_rsv ? 32'h0000_0000 :
      hit_bus ? rd_bus :
      hit_io ? rd_io : 32'h0000_0000;

   // Next values; read-only fields have no write path at all
   wire logic [LINE_W-1:0] next_line_size =
      (hit_header & lane_wr[0]) ? dat_i[LINE_LO +: LINE_W] : line_size;
   wire logic [7:0] next_upstream_timer =
      forward ? 8'h00 :
      (hit_header & lane_wr[1]) ? dat_i[15:8] : upstream_latency_timer;
   wire logic [7:0] next_downstream_timer =
      !forward ? 8'h00 :
      (hit_bus & lane_wr[3]) ? dat_i[31:24] : downstream_latency_timer;
   wire logic [7:0] next_upstream_bus =
      (hit_bus & lane_wr[0]) ? dat_i[7:0] : upstream_bus_number;
   wire logic [7:0] next_downstream_bus =
      (hit_bus & lane_wr[1]) ? dat_i[15:8] : downstream_bus_number;
   wire logic [7:0] next_highest_bus =
      (hit_bus & lane_wr[2]) ? dat_i[23:16] : highest_bus_number;
   wire logic [IO_NIB_W-1:0] next_io_base =
      (hit_io & lane_wr[0]) ? dat_i[7:4] : io_window_base;
   wire logic [IO_NIB_W-1:0] next_io_limit =
      (hit_io & lane_wr[1]) ? dat_i[15:12] : io_window_limit;

   // Timer reset values follow the straps sampled during reset
   wire logic [7:0] up_timer_rst = forward ? 8'h00 : timer_rst;
   wire logic [7:0] dn_timer_rst = forward ? timer_rst : 8'h00;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         upstream_latency_timer <= up_timer_rst;
         downstream_latency_timer <= dn_timer_rst;
      end else begin
         upstream_latency_timer <= next_upstream_timer;
         downstream_latency_timer <= next_downstream_timer;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         line_size <= LINE_RST;
         upstream_bus_number <= BUS_RST;
         downstream_bus_number <= BUS_RST;
         highest_bus_number <= BUS_RST;
      end else begin
         line_size <= next_line_size;
         upstream_bus_number <= next_upstream_bus;
         downstream_bus_number <= next_downstream_bus;
         highest_bus_number <= next_highest_bus;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         io_window_base <= IO_NIB_RST;
         io_window_limit <= IO_NIB_RST;
      end else begin
         io_window_base <= next_io_base;
         io_window_limit <= next_io_limit;
      end
   end

   // One wait state: ack and read data one edge after the request appears
   wire logic take = req & !ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= take;
         dat_o <= take ? rdata : dat_o;
      end
   end

   assign line_size_o = line_size;
   assign upstream_timer_o = upstream_latency_timer;
   assign downstream_timer_o = downstream_latency_timer;
   assign upstream_bus_o = upstream_bus_number;
   assign downstream_bus_o = downstream_bus_number;
   assign highest_bus_o = highest_bus_number;
   assign io_base_o = io_window_base;
   assign io_limit_o = io_window_limit;

   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   wire logic rd_take = take & !we_i;
   wire logic hit_any = hit_class | hit_header | hit_rsv | hit_bus | hit_io;
   wire logic [31:0] bus_image = {downstream_timer_o, highest_bus_o, downstream_bus_o,
                                  upstream_bus_o};
   // Every writable field except the timers, whose value also follows the straps
   wire logic [35:0] held_fields = {line_size_o, upstream_bus_o, downstream_bus_o,
                                    highest_bus_o, io_base_o, io_limit_o};

   // Bus handshake
   a_ack_timing: assert property (take |=> ack_o ##1 !ack_o)
      else $error("ack not given one cycle after request");

   a_ack_cause: assert property (ack_o |->
         $past(take))
      else $error("ack without a pending request");

   a_ack_reset: assert property ($past(rst_i) |->
         !ack_o && dat_o == 32'h0000_0000)
      else $error("bus outputs not cleared by reset");

   a_data_hold: assert property (!take |=>
         $stable(dat_o))
      else $error("read data changed without a request");

   // Fixed identification fields
   a_class_read: assert property (rd_take & hit_class |=>
         dat_o == {8'h06, 8'h04, 8'h00, REVISION})
      else $error("class dword read wrong");

   a_prog_if_zero: assert property (rd_take & hit_class |=>
         dat_o[15:8] == 8'h00)
      else $error("programming interface byte not zero");

   a_sub_class: assert property (rd_take & hit_class |=>
         dat_o[23:16] == 8'h04)
      else $error("sub-class byte wrong");

   a_base_class: assert property (rd_take & hit_class |=>
         dat_o[31:24] == 8'h06)
      else $error("base class byte wrong");

   a_header_read: assert property (rd_take & hit_header |=>
         dat_o[22:16] == 7'h01)
      else $error("header layout field wrong");

   a_single_fn: assert property (rd_take & hit_header |=>
         dat_o[31:23] == 9'h000)
      else $error("header top bits not zero");

   // Read images of the programmed fields, the fixed I/O bits and reserved or unmapped dwords
   a_line_read: assert property (rd_take & hit_header |=>
         dat_o[5:2] == $past(line_size_o))
      else $error("line size read wrong");

   a_line_pads: assert property (rd_take & hit_header |=>
         dat_o[1:0] == 2'b00 && dat_o[7:6] == 2'b00)
      else $error("line size unused bits not zero");

   a_up_timer_read: assert property (rd_take & hit_header |=>
         dat_o[15:8] == $past(upstream_timer_o))
      else $error("upstream timer read wrong");

   a_bus_read: assert property (rd_take & hit_bus |=>
         dat_o == $past(bus_image))
      else $error("bus number dword read wrong");

   a_io_caps: assert property (rd_take & hit_io |=>
         dat_o[3:0] == 4'h1 && dat_o[11:8] == 4'h1 && dat_o[31:16] == 16'h0)
      else $error("io dword fixed bits wrong");

   a_io_base_read: assert property (rd_take & hit_io |=>
         dat_o[7:4] == $past(io_base_o))
      else $error("io base read wrong");

   a_io_limit_read: assert property (rd_take & hit_io |=>
         dat_o[15:12] == $past(io_limit_o))
      else $error("io limit read wrong");

   a_rsv_zero: assert property (rd_take & hit_rsv |=> dat_o == 32'h0)
      else $error("reserved dword not zero");

   a_unmapped_zero: assert property (rd_take & !hit_any |=>
         dat_o == 32'h0000_0000)
      else $error("unmapped dword not zero");

   // Reset values
   a_timer_reset: assert property ($past(rst_i) && forward |->
         downstream_timer_o == ($past(pcix) ? 8'h40 : 8'h00))
      else $error("downstream timer reset value wrong");

   a_up_timer_reset: assert property ($past(rst_i) && !forward |->
         upstream_timer_o == ($past(pcix) ? 8'h40 : 8'h00))
      else $error("upstream timer reset value wrong");

   a_line_reset: assert property ($past(rst_i) |->
         line_size_o == 4'h0)
      else $error("line size reset value wrong");

   a_bus_reset: assert property ($past(rst_i) |->
         upstream_bus_o == 8'h00)
      else $error("upstream bus number reset value wrong");

   a_bus_pair_reset: assert property ($past(rst_i) |->
         downstream_bus_o == 8'h00 && highest_bus_o == 8'h00)
      else $error("downstream bus numbers reset value wrong");

   a_io_reset: assert property ($past(rst_i) |->
         io_base_o == 4'h0 && io_limit_o == 4'h0)
      else $error("io window reset value wrong");

   // Strap-dependent timers
   a_fwd_up_zero: assert property (forward && $past(forward) |->
         upstream_timer_o == 8'h00)
      else $error("upstream timer not zero in forward mode");

   a_rev_dn_zero: assert property (!forward && !$past(forward) |->
         downstream_timer_o == 8'h00)
      else $error("downstream timer not zero in reverse mode");

   a_up_timer_write: assert property (wr & hit_header & sel_i[1] & !forward |=>
         upstream_timer_o == $past(dat_i[15:8]))
      else $error("upstream timer write lost");

   a_up_timer_keep: assert property (!wr && !forward |=>
         $stable(upstream_timer_o))
      else $error("upstream timer changed without a write");

   a_dn_timer_write: assert property (wr & hit_bus & sel_i[3] & forward |=>
         downstream_timer_o == $past(dat_i[31:24]))
      else $error("downstream timer write lost");

   a_dn_timer_keep: assert property (!wr && forward |=>
         $stable(downstream_timer_o))
      else $error("downstream timer changed without a write");

   // Write paths and byte lanes
   a_bus_write: assert property (wr & hit_bus & sel_i[0] |=>
         upstream_bus_o == $past(dat_i[7:0]))
      else $error("upstream bus number write lost");

   a_bus_lane0_keep: assert property (wr & hit_bus & !sel_i[0] |=>
         $stable(upstream_bus_o))
      else $error("unselected upstream bus lane changed");

   a_down_bus_write: assert property (wr & hit_bus & sel_i[1] |=>
         downstream_bus_o == $past(dat_i[15:8]))
      else $error("downstream bus number write lost");

   a_high_bus_write: assert property (wr & hit_bus & sel_i[2] |=>
         highest_bus_o == $past(dat_i[23:16]))
      else $error("highest bus number write lost");

   a_lane_keep: assert property (wr & hit_bus & !sel_i[1] |=> $stable(downstream_bus_o))
      else $error("unselected byte lane changed");

   a_high_keep: assert property (wr & hit_bus & !sel_i[2] |=>
         $stable(highest_bus_o))
      else $error("unselected highest bus lane changed");

   a_line_write: assert property (wr & hit_header & sel_i[0] |=>
         line_size_o == $past(dat_i[5:2]))
      else $error("line size write lost");

   a_line_keep: assert property (wr & hit_header & !sel_i[0] |=>
         $stable(line_size_o))
      else $error("unselected line size lane changed");

   a_io_write: assert property (wr & hit_io & sel_i[1] |=>
         io_limit_o == $past(dat_i[15:12]))
      else $error("io limit write lost");

   a_io_base_write: assert property (wr & hit_io & sel_i[0] |=>
         io_base_o == $past(dat_i[7:4]))
      else $error("io base write lost");

   a_io_keep: assert property (wr & hit_io & !sel_i[1] |=>
         $stable(io_limit_o))
      else $error("unselected io limit lane changed");

   a_idle_keep: assert property (!wr |=>
         $stable(held_fields))
      else $error("programmed field changed without a write");

   a_ro_keep: assert property (wr & (hit_class | hit_rsv | !hit_any) |=>
         $stable(held_fields))
      else $error("read-only dword write changed a field");

   // Scenarios the bench is expected to reach; c_bus_write is not, as the bench never writes 18h with all four lanes
   c_class_read: cover property (rd_take & hit_class);
   c_pcix_reset: cover property ($past(rst_i) && pcix);
   c_bus_write: cover property (wr & hit_bus & (sel_i == 4'hf));
   c_rev_timer: cover property (wr & hit_header & sel_i[1] & !forward);
   c_unmapped: cover property (rd_take & !(hit_class | hit_header | hit_rsv | hit_bus | hit_io));

endmodule : bridge_config_header_regs

`default_nettype wire

//--- design/bridge_cfg_pkg.sv
/*
 Constants for the bridge configuration header register bank: dword offsets,
 field positions, fixed codes and reset values.
 Assumes byte offsets on a 32-bit Wishbone bus, one aligned dword per offset.
*/
// Functional notes
// - Revision byte at 08h bits 7:0 is read-only with a fixed code.
// - Programming interface byte, bits 15:8, reads zero: no subtractive decode.
// - Sub-class byte, bits 23:16, read-only, reports a bridge-to-bridge sub-class.
// - Base class byte, bits 31:24, read-only, reports a bridge device.
// - Line size bits 2..5 writable, reset zero, select 4/8/16/32 dword lines.
// - Line size bits 1:0 and 7:6 read zero and ignore writes.
// - Upstream timer RO zero forward; RW reverse, reset 00h or 40h by bus mode.
// - Downstream timer RW forward, reset 00h or 40h by mode; RO zero reverse.
// - Header layout bits 22:16 read-only, value 0000001.
// - Header bit 23 reads zero (single function); bits 31:24 read zero.
// - Offsets 10h to 17h reserved, no base address registers.
// - Upstream bus number at 18h bits 7:0 writable, reset zero.
// - Downstream and highest bus numbers at 18h writable, reset zero.
// - I/O base bits 1:0 and limit bits 9:8 read-only 01: 32-bit I/O.
// - I/O base nibble 7:4 writable, reset zero; bits 3:2 read zero.
// - I/O limit nibble 15:12 writable, reset zero; bits 11:10 read zero.
`default_nettype none

package bridge_cfg_pkg;
   localparam int ADR_W = 8;
   localparam logic [ADR_W-1:0] OFS_CLASS = 8'h08;
   localparam logic [ADR_W-1:0] OFS_HEADER = 8'h0c;
   localparam logic [ADR_W-1:0] OFS_RSV0 = 8'h10;
   localparam logic [ADR_W-1:0] OFS_RSV1 = 8'h14;
   localparam logic [ADR_W-1:0] OFS_BUS = 8'h18;
   localparam logic [ADR_W-1:0] OFS_IO = 8'h1c;

   localparam logic [7:0] PROG_IF = 8'h00;
   localparam logic [7:0] SUB_CLASS = 8'h04;
   localparam logic [7:0] BASE_CLASS = 8'h06;
   localparam logic [6:0] HDR_LAYOUT = 7'h01;
   localparam logic HDR_MULTI_FN = 1'b0;
   localparam logic [7:0] HDR_TOP = 8'h00;

   localparam int LINE_LO = 2;
   localparam int LINE_W = 4;
   localparam logic [LINE_W-1:0] LINE_RST = 4'h0;

   localparam logic [7:0] TIMER_RST_PCI = 8'h00;
   localparam logic [7:0] TIMER_RST_PCIX = 8'h40;
   localparam logic [7:0] BUS_RST = 8'h00;

   localparam logic [1:0] IO_ADDR_CAP = 2'h1;
   localparam int IO_NIB_W = 4;
   localparam logic [IO_NIB_W-1:0] IO_NIB_RST = 4'h0;

   localparam int STRAP_W = 2;
   localparam int STRAP_FWD = 0;
   localparam int STRAP_PCIX = 1;
endpackage : bridge_cfg_pkg

`default_nettype wire

//--- tb/test_bridge_config_header_regs.sv
/*
 Self-checking bench for the bridge configuration header register bank.
 Assumes the classic Wishbone slave answers one cycle after it takes a request,
 and that the direction and bus mode straps are only changed around a reset.
*/
`default_nettype none

module test_bridge_config_header_regs import bridge_cfg_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [7:0] REV = 8'h3c;  // Value is arbitrary

   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0;
   logic [3:0] sel_i = 4'h0;
   logic we_i = 1'b0;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic forward_mode_i = 1'b1;
   logic pcix_mode_i = 1'b0;
   logic [31:0] dat_o;
   logic ack_o;
   logic [3:0] line_size_o, io_base_o, io_limit_o;
   logic [7:0] upstream_timer_o, downstream_timer_o;
   logic [7:0] upstream_bus_o, downstream_bus_o, highest_bus_o;
   int mismatches = 0;
   int compares = 0;
   logic [31:0] q;

   bridge_config_header_regs #(.REVISION(REV)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
      .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
      .forward_mode_i(forward_mode_i), .pcix_mode_i(pcix_mode_i),
      .line_size_o(line_size_o), .upstream_timer_o(upstream_timer_o),
      .downstream_timer_o(downstream_timer_o), .upstream_bus_o(upstream_bus_o),
      .downstream_bus_o(downstream_bus_o), .highest_bus_o(highest_bus_o),
      .io_base_o(io_base_o), .io_limit_o(io_limit_o)
   );

   initial begin
      forever #5 clk_i = ~clk_i;
   end

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         mismatches++;
      end
   endtask : chk

   // One classic cycle; request held until ack is sampled high at a rising edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      if (n >= 20) begin
         $display("wrong value ack expected 1 seen %b", ack_o);
         mismatches++;
         report_and_stop();
      end
   endtask : wb

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      wb(1'b0, a, 4'hf, 32'h0, v);
      chk(name, exp, v);
   endtask : rd_chk

   // Straps settle while reset is held, so the timer reset values follow them
   task automatic do_reset(input logic fwd, input logic pcix);
      @(posedge clk_i);
      rst_i <= 1'b1;
      forward_mode_i <= fwd;
      pcix_mode_i <= pcix;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask : do_reset

   task automatic t_reset_values;
      do_reset(1'b1, 1'b0);
      rd_chk("class dword", 8'h08, {8'h06, 8'h04, 8'h00, REV});
      rd_chk("header dword", 8'h0c, 32'h0001_0000);
      rd_chk("bus dword", 8'h18, 32'h0);
      rd_chk("io dword", 8'h1c, 32'h0000_0101);
      chk("bus outputs", 32'h0, {8'h00, upstream_bus_o, downstream_bus_o, highest_bus_o});
      $display("reset values done");
   endtask : t_reset_values

   task automatic t_read_only_writes;
      wb(1'b1, 8'h08, 4'hf, 32'hffff_ffff, q);
      rd_chk("class after write", 8'h08, {8'h06, 8'h04, 8'h00, REV});
      wb(1'b1, 8'h0c, 4'hf, 32'hffff_ffff, q);
      rd_chk("header after write", 8'h0c, 32'h0001_003c);
      chk("line size out", 32'hf, {28'h0, line_size_o});
      wb(1'b1, 8'h0c, 4'h1, 32'h0000_0084, q);
      rd_chk("line lane only", 8'h0c, 32'h0001_0004);
      wb(1'b1, 8'h10, 4'hf, 32'hffff_ffff, q);
      rd_chk("reserved 10h", 8'h10, 32'h0);
      wb(1'b1, 8'h14, 4'hf, 32'hffff_ffff, q);
      rd_chk("reserved 14h", 8'h14, 32'h0);
      rd_chk("unmapped 20h", 8'h20, 32'h0);
      rd_chk("bus after reserved", 8'h18, 32'h0);
      rd_chk("io after reserved", 8'h1c, 32'h0000_0101);
      $display("read-only writes done");
   endtask : t_read_only_writes

   task automatic t_bus_and_io;
      do_reset(1'b1, 1'b1);
      rd_chk("fwd pcix bus dword", 8'h18, 32'h4000_0000);
      wb(1'b1, 8'h18, 4'h5, 32'h8877_6655, q);
      rd_chk("bus lanes 0 2", 8'h18, 32'h4077_0055);
      wb(1'b1, 8'h18, 4'ha, 32'h8877_6655, q);
      rd_chk("bus lanes 1 3", 8'h18, 32'h8877_6655);
      chk("bus outputs", 32'h8855_6677,
          {downstream_timer_o, upstream_bus_o, downstream_bus_o, highest_bus_o});
      chk("up timer fwd", 32'h0, {24'h0, upstream_timer_o});
      wb(1'b1, 8'h1c, 4'hf, 32'hffff_ffff, q);
      rd_chk("io all ones", 8'h1c, 32'h0000_f1f1);
      wb(1'b1, 8'h1c, 4'h1, 32'h0000_0000, q);
      rd_chk("io base lane", 8'h1c, 32'h0000_f101);
      chk("io outputs", 32'h0f, {24'h0, io_base_o, io_limit_o});
      $display("bus and io done");
   endtask : t_bus_and_io

   task automatic t_timer_modes;
      logic [7:0] up, dn;
      for (int i = 0; i < 4; i++) begin
         do_reset(i[1], i[0]);
         up = i[1] ? 8'h00 : (i[0] ? 8'h40 : 8'h00);
         dn = i[1] ? (i[0] ? 8'h40 : 8'h00) : 8'h00;
         rd_chk("timer reset 0ch", 8'h0c, {16'h0001, up, 8'h00});
         rd_chk("timer reset 18h", 8'h18, {dn, 24'h0});
         wb(1'b1, 8'h0c, 4'h2, 32'h0000_a500, q);
         wb(1'b1, 8'h18, 4'h8, 32'hc300_0000, q);
         rd_chk("up timer write", 8'h0c, {16'h0001, i[1] ? 8'h00 : 8'ha5, 8'h00});
         rd_chk("dn timer write", 8'h18, {i[1] ? 8'hc3 : 8'h00, 24'h0});
      end
      $display("timer modes done");
   endtask : t_timer_modes

   initial begin
      t_reset_values();
      t_read_only_writes();
      t_bus_and_io();
      t_timer_modes();
      report_and_stop();
   end
endmodule : test_bridge_config_header_regs

`default_nettype wire
